/* dv/isr_host_model.sv */
// Host model: serial master and sync clock source
`timescale 1ns/100ps
`default_nettype none
module isr_host_model (
   output logic spi_sclk, // Serial clock, idles high
   output logic spi_cs_n, // Chip select
   output logic spi_mosi, // Data to device
   input wire logic spi_miso, // Data from device
   output logic sync_out // Sync clock
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      sync_out = 1'b0;
   end
   // Change on falling, take on rising, select held
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      #7.3;
      spi_cs_n = 1'b0;
      #80;
      for (int i = 0; i < nbits; i++) begin
         spi_sclk = 1'b0;
         spi_mosi = tx[15-i];
         #80;
         spi_sclk = 1'b1;
         rx = {rx[14:0], spi_miso};
         #80;
      end
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      // Idle covers word stall and read spacing
      #40000;
   endtask
   // Burst: select held over several words, serial clock at 1 MHz
   task automatic burst(input logic [15:0] tx, input int nwords, output logic [15:0] rx);
      rx = 16'h0000;
      #7.3;
      spi_cs_n = 1'b0;
      #500;
      for (int i = 0; i < 16 * nwords; i++) begin
         spi_sclk = 1'b0;
         spi_mosi = tx[15 - (i % 16)];
         #500;
         spi_sclk = 1'b1;
         rx = {rx[14:0], spi_miso};
         #500;
         // Stall of one clock period between burst words; spacing rules waived
         if (i % 16 == 15) #1000;
      end
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #40000;
   endtask
   // High 5 us, low 100 us, one rising edge per call
   task automatic sync_pulse();
      sync_out = 1'b1;
      #5000;
      sync_out = 1'b0;
      #100000;
   endtask
endmodule
`default_nettype wire

/* dv/isr_sensor_if_sva.sv */
// Port-level assertions for the sensor readout interface
`timescale 1ns/100ps
`default_nettype none
module isr_sensor_if_sva #(
   parameter int unsigned SAMPLE_CYC_P = 300,
   parameter int unsigned SYNC_DR_CYC_P = 50
) (
   input wire logic sys_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic rst_pin_n, // Reset pin
   input wire logic [isr_pkg::WORD_W-1:0] sample_period_setting, // Period
   input wire logic sync_sel, // Sync select
   input wire logic smp_ready, // Sample taken
   input wire logic data_valid, // Run phase
   input wire logic data_ready_pin, // Data ready
   input wire logic gpio_four_oe, // Pin enable request
   input wire logic sync_clock_pin_i, // Fourth pin
   input wire logic sync_clock_pin_oe, // Fourth pin enable
   input wire logic spi_cs_n, // Chip select
   input wire logic spi_miso_o, // Serial out
   input wire logic spi_miso_oe // Serial out enable
);
   import isr_pkg::*;
   localparam int DR_LO = SYNC_DR_CYC_P + 1;
   localparam int DR_HI = SYNC_DR_CYC_P + 4;
   logic dr_ff, seen_ff;
   logic [CNT_W-1:0] gap_ff;
   wire logic ext = (sample_period_setting == SMPL_SYNC_SETTING) && sync_sel;
   wire logic dr_rise = data_ready_pin && !dr_ff;
   // Period only judged between two pulses of one unbroken internal run
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dr_ff <= 1'b0;
         seen_ff <= 1'b0;
         gap_ff <= '0;
      end else begin
         dr_ff <= data_ready_pin;
         seen_ff <= data_valid && !ext && (seen_ff || dr_rise);
         gap_ff <= dr_rise ? CNT_W'(1) : gap_ff + 1'b1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_miso_en_cs: assert property (spi_miso_oe == !spi_cs_n)
      else $error("serial out enable wrong");
   a_miso_idle_low: assert property (spi_cs_n |-> !spi_miso_o)
      else $error("serial out active while deselected");
   a_pin_drive_sel: assert property (sync_clock_pin_oe == (gpio_four_oe && !sync_sel))
      else $error("fourth pin enable wrong");
   a_ready_needs_run: assert property (smp_ready |-> data_valid)
      else $error("sample taken outside run");
   a_dr_pulse_width: assert property ($rose(data_ready_pin) |-> ##49 data_ready_pin ##1 !data_ready_pin)
      else $error("data ready width wrong");
   a_dr_sample_period: assert property ($rose(data_ready_pin) && seen_ff |-> gap_ff == CNT_W'(SAMPLE_CYC_P))
      else $error("data ready period wrong");
   a_sync_dr_delay: assert property ($rose(sync_clock_pin_i) && ext && data_valid |-> ##[DR_LO:DR_HI] $rose(data_ready_pin))
      else $error("sync to data ready delay wrong");
   a_reset_pin_drop: assert property ($fell(rst_pin_n) |-> ##[1:4] !data_valid)
      else $error("reset pin did not stop data");
   c_dr_period: cover property ($rose(data_ready_pin) && seen_ff);
   c_sync_mode: cover property ($rose(sync_clock_pin_i) && ext);
   c_fifo_full: cover property (data_valid && !smp_ready);
endmodule
`default_nettype wire

/* dv/isr_sensor_if_tb_top.sv */
// Testbench for the sensor readout interface
`timescale 1ns/100ps
`default_nettype none
module isr_sensor_if_tb_top;
   import isr_pkg::*;
   localparam int BOOT_N = 200;
   localparam int SYNC_N = 50;
   localparam int OUT_N [3] = '{80, 60, 100};
   localparam int SEL_READY = 0, SEL_VALID = 1, SEL_DR = 2;
   logic sys_clk = 1'b0, resetn = 1'b0, rst_pin_n = 1'b1, sync_sel = 1'b0;
   logic flash_test_start = 1'b0, self_test_start = 1'b0, smp_valid = 1'b0;
   logic gpio_four_out = 1'b0, gpio_four_oe = 1'b0;
   logic [15:0] sample_period_setting = 16'h0001, smp_data = 16'h0000, cmd_word, rx;
   logic smp_ready, cmd_valid, data_valid, data_ready_pin, gpio_four_in;
   logic sync_o, sync_oe, miso_o, miso_oe, spi_sclk, spi_cs_n, spi_mosi, host_sync;
   wire logic sync_pin = sync_oe ? sync_o : host_sync;
   // Released serial out shows the inverse, so a late sample is caught
   wire logic miso_line = miso_oe ? miso_o : ~miso_o;
   int num_errors = 0, num_checks = 0, cmd_cnt = 0, n, m;
   // Host word sent, word expected back
   logic [15:0] rows [4][2] = '{'{16'h8001, 16'h0000}, '{16'h3e00, 16'h0a00},
      '{16'h0400, 16'h0a01}, '{16'hffff, 16'h0a02}};
   isr_sensor_if #(.STARTUP_CYC_P(BOOT_N), .RECOVER_CYC_P(OUT_N[2]), .FLASH_TEST_CYC_P(OUT_N[0]),
      .SELF_TEST_CYC_P(OUT_N[1]), .SAMPLE_CYC_P(300), .SYNC_DR_CYC_P(SYNC_N)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .rst_pin_n(rst_pin_n),
      .flash_test_start(flash_test_start), .self_test_start(self_test_start),
      .sample_period_setting(sample_period_setting), .sync_sel(sync_sel),
      .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid), .data_valid(data_valid), .data_ready_pin(data_ready_pin),
      .gpio_four_out(gpio_four_out), .gpio_four_oe(gpio_four_oe), .gpio_four_in(gpio_four_in),
      .sync_clock_pin_i(sync_pin), .sync_clock_pin_o(sync_o), .sync_clock_pin_oe(sync_oe),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(miso_o),
      .spi_miso_oe(miso_oe));
   isr_host_model u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(miso_line), .sync_out(host_sync));
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (cmd_valid === 1'b1) cmd_cnt++;
   task tick();
      @(posedge sys_clk);
      #1;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         SEL_READY: return smp_ready;
         SEL_VALID: return data_valid;
         default: return data_ready_pin;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic lvl, output int k);
      k = 0;
      while (pick(sel) !== lvl) begin
         tick();
         k++;
         if (k > 400) begin
            num_errors++;
            close_out();
         end
      end
   endtask
   task automatic push(input logic [15:0] d);
      smp_valid = 1'b1;
      smp_data = d;
      wait_for(SEL_READY, 1'b1, m);
      tick();
   endtask
   task automatic xf(input logic [15:0] tx, input logic [15:0] exp);
      int c;
      c = cmd_cnt;
      u_host.frame(tx, 16, rx);
      check(rx, exp);
      check(cmd_word, tx);
      check(16'(cmd_cnt - c), 16'h1);
   endtask
   // Start right after a pulse ends, so no pulse is cut short
   task automatic quiet();
      wait_for(SEL_DR, 1'b1, m);
      wait_for(SEL_DR, 1'b0, m);
   endtask
   task automatic outage(input int k, input int lo);
      quiet();
      flash_test_start = (k == 0);
      self_test_start = (k == 1);
      rst_pin_n = (k != 2);
      tick();
      flash_test_start = 1'b0;
      self_test_start = 1'b0;
      rst_pin_n = 1'b1;
      wait_for(SEL_VALID, 1'b0, m);
      wait_for(SEL_VALID, 1'b1, n);
      check(16'(m + n >= lo && m + n <= lo + 6), 16'h1);
   endtask
   initial begin
      #2000000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      wait_for(SEL_VALID, 1'b1, n);
      check(16'(n >= BOOT_N && n <= BOOT_N + 2), 16'h1);
      for (int i = 0; i < 16; i++) push(16'h0a00 + 16'(i));
      check({15'h0, smp_ready}, 16'h0);
      smp_valid = 1'b0;
      foreach (rows[i]) xf(rows[i][0], rows[i][1]);
      n = cmd_cnt;
      u_host.frame(16'h1234, 8, rx);
      check(rx, 16'h000a);
      check(16'(cmd_cnt - n), 16'h0);
      check(cmd_word, 16'hffff);
      for (int k = 3; k < 16; k++) xf(~(16'h0a00 + 16'(k)), 16'h0a00 + 16'(k));
      xf(16'h5a5a, 16'h0000);
      push(16'h0b00);
      push(16'h0b01);
      smp_valid = 1'b0;
      n = cmd_cnt;
      u_host.burst(16'h3e00, 3, rx);
      check(rx, 16'h0b01);
      check(16'(cmd_cnt - n), 16'h3);
      check(cmd_word, 16'h3e00);
      for (int k = 0; k < 3; k++) outage(k, OUT_N[k]);
      gpio_four_oe = 1'b1;
      gpio_four_out = 1'b1;
      repeat (3) tick();
      check({13'h0, sync_o, sync_oe, gpio_four_in}, 16'h7);
      quiet();
      sample_period_setting = 16'h0000;
      sync_sel = 1'b1;
      tick();
      check({15'h0, sync_oe}, 16'h0);
      fork
         u_host.sync_pulse();
         wait_for(SEL_DR, 1'b1, n);
      join
      check(16'(n >= SYNC_N + 1 && n <= SYNC_N + 4), 16'h1);
      close_out();
   end
endmodule
bind isr_sensor_if isr_sensor_if_sva #(.SAMPLE_CYC_P(SAMPLE_CYC_P),
   .SYNC_DR_CYC_P(SYNC_DR_CYC_P)) u_sva (.sys_clk(sys_clk), .resetn(resetn),
   .rst_pin_n(rst_pin_n), .sample_period_setting(sample_period_setting), .sync_sel(sync_sel),
   .smp_ready(smp_ready), .data_valid(data_valid), .data_ready_pin(data_ready_pin),
   .gpio_four_oe(gpio_four_oe), .sync_clock_pin_i(sync_clock_pin_i),
   .sync_clock_pin_oe(sync_clock_pin_oe), .spi_cs_n(spi_cs_n), .spi_miso_o(spi_miso_o),
   .spi_miso_oe(spi_miso_oe));
`default_nettype wire

/* src/isr_fifo.sv */
// Sample word FIFO between the sample source and the serial output
`timescale 1ns/100ps
`default_nettype none
module isr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic in_valid, // Write request
   input wire logic [WIDTH-1:0] in_data, // Write word
   output logic in_ready, // Room for a word
   output logic out_valid, // Word available
   output logic [WIDTH-1:0] out_data, // Oldest word
   input wire logic out_ready // Pop request
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } isr_fifo_t;

   isr_fifo_t fifo_ff;
   isr_fifo_t nxt_fifo_ff;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign full = (fifo_ff.wr_ptr[AW] != fifo_ff.rd_ptr[AW]) &&
                 (fifo_ff.wr_ptr[AW-1:0] == fifo_ff.rd_ptr[AW-1:0]);
   assign empty = fifo_ff.wr_ptr == fifo_ff.rd_ptr;
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = fifo_ff.mem[fifo_ff.rd_ptr[AW-1:0]];

   always_comb begin
      nxt_fifo_ff = fifo_ff;
      if (in_valid && !full) begin
         nxt_fifo_ff.mem[fifo_ff.wr_ptr[AW-1:0]] = in_data;
         nxt_fifo_ff.wr_ptr = fifo_ff.wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
         nxt_fifo_ff.rd_ptr = fifo_ff.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_ff <= '0;
      end else begin
         fifo_ff <= nxt_fifo_ff;
      end
   end
endmodule
`default_nettype wire

/* src/isr_pkg.sv */
// Shared constants and types for the inertial sensor readout interface
package isr_pkg;
   // Clock rates
   localparam int unsigned CLK_KHZ = 50000;
   localparam int unsigned CLK_MHZ = 50;

   // Functional times, in their own units
   localparam int unsigned STARTUP_MS = 180;
   localparam int unsigned RECOVER_MS = 60;
   localparam int unsigned FLASH_TEST_MS = 20;
   localparam int unsigned SELF_TEST_MS = 14;
   localparam int unsigned STARTUP_CYC = STARTUP_MS * CLK_KHZ;
   localparam int unsigned RECOVER_CYC = RECOVER_MS * CLK_KHZ;
   localparam int unsigned FLASH_TEST_CYC = FLASH_TEST_MS * CLK_KHZ;
   localparam int unsigned SELF_TEST_CYC = SELF_TEST_MS * CLK_KHZ;

   // Internal sample rate in tenths of a sample per second; period rounds down
   localparam int unsigned SAMPLE_RATE_DSPS = 8192;
   localparam int unsigned SAMPLE_CYC = (CLK_KHZ * 10000) / SAMPLE_RATE_DSPS;

   // Sync edge to data ready, and data ready pulse width
   localparam int unsigned SYNC_DR_US = 600;
   localparam int unsigned SYNC_DR_CYC = SYNC_DR_US * CLK_MHZ;
   localparam int unsigned DR_PULSE_US = 1;
   localparam int unsigned DR_PULSE_CYC = DR_PULSE_US * CLK_MHZ;

   // Field and counter widths
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int BIT_CNT_W = 4;
   localparam int CNT_W = 24;
   localparam int SMP_W = 16;
   localparam int DLY_W = 15;
   localparam int PULSE_W = 8;

   // Values
   localparam logic [WORD_W-1:0] SMPL_SYNC_SETTING = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;

   typedef enum logic [4:0] {
      ST_BOOT = 5'h01,
      ST_RECOVER = 5'h02,
      ST_FLASH = 5'h04,
      ST_SELFTEST = 5'h08,
      ST_RUN = 5'h10
   } isr_phase_t;
endpackage

/* src/isr_sensor_if.sv */
// Serial readout, sample timebase and functional timing of the inertial sensor
//
// Functional notes
// - Data valid 180 ms after power-on, 60 ms after reset; self-test takes 14 ms.
// - Flash memory test runs about 20 ms before output data is trusted again.
// - Untouched, samples run at 819.2 per second, data ready pulses each one.
// - Period setting zero with sync select set paces sampling from external sync clock, 0.8 to 1.2 kHz.
// - Fourth digital pin serves as general input/output or as sync clock input.
// - In sync mode data ready rises about 600 us after each rising sync edge.
// - Serial output bits launch on the falling serial clock edge.
// - Serial input bits are captured on the rising serial clock edge.
// - Interface works only while chip select is held low.
`timescale 1ns/100ps
`default_nettype none
module isr_sensor_if #(
   parameter int unsigned STARTUP_CYC_P = isr_pkg::STARTUP_CYC,
   parameter int unsigned RECOVER_CYC_P = isr_pkg::RECOVER_CYC,
   parameter int unsigned FLASH_TEST_CYC_P = isr_pkg::FLASH_TEST_CYC,
   parameter int unsigned SELF_TEST_CYC_P = isr_pkg::SELF_TEST_CYC,
   parameter int unsigned SAMPLE_CYC_P = isr_pkg::SAMPLE_CYC,
   parameter int unsigned SYNC_DR_CYC_P = isr_pkg::SYNC_DR_CYC
) (
   input wire logic sys_clk, // System clock, 50 MHz
   input wire logic resetn, // Power-on reset, async, active low
   input wire logic rst_pin_n, // Reset pin, async, active low
   input wire logic flash_test_start, // Start flash test, pulse
   input wire logic self_test_start, // Start self-test, pulse
   input wire logic [isr_pkg::WORD_W-1:0] sample_period_setting, // Zero selects sync
   input wire logic sync_sel, // Fourth pin acts as sync clock
   input wire logic smp_valid, // Sample word offered
   input wire logic [isr_pkg::WORD_W-1:0] smp_data, // Sample word
   output logic smp_ready, // Sample word taken
   output logic [isr_pkg::WORD_W-1:0] cmd_word, // Last word from host
   output logic cmd_valid, // New host word, pulse
   output logic data_valid, // Output data valid, level
   output logic data_ready_pin, // Data ready pulse
   input wire logic gpio_four_out, // General output level
   input wire logic gpio_four_oe, // General output enable
   output logic gpio_four_in, // Synchronised pin level
   input wire logic sync_clock_pin_i, // Fourth pin, input
   output logic sync_clock_pin_o, // Fourth pin, output
   output logic sync_clock_pin_oe, // Fourth pin, enable
   input wire logic spi_sclk, // Serial clock, idles high
   input wire logic spi_cs_n, // Chip select, active low
   input wire logic spi_mosi, // Serial data in
   output logic spi_miso_o, // Serial data out
   output logic spi_miso_oe // Serial data out enable
);
   import isr_pkg::*;

   localparam logic [CNT_W-1:0] STARTUP_LOAD = CNT_W'(STARTUP_CYC_P - 1);
   localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYC_P - 1);
   localparam logic [CNT_W-1:0] FLASH_LOAD = CNT_W'(FLASH_TEST_CYC_P - 1);
   localparam logic [CNT_W-1:0] SELF_LOAD = CNT_W'(SELF_TEST_CYC_P - 1);
   localparam logic [SMP_W-1:0] SMP_LOAD = SMP_W'(SAMPLE_CYC_P - 1);
   localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(SYNC_DR_CYC_P - 1);
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(DR_PULSE_CYC - 1);

   typedef struct packed {
      isr_phase_t phase;
      logic [CNT_W-1:0] busy_cnt;
      logic [SMP_W-1:0] smp_cnt;
      logic [DLY_W-1:0] dly_cnt;
      logic dly_run;
      logic [PULSE_W-1:0] dr_cnt;
      logic data_ready;
      logic sync_s1;
      logic sync_s2;
      logic sync_s3;
      logic hwrst_s1_n;
      logic hwrst_s2_n;
      logic word_s1;
      logic word_s2;
      logic word_s3;
      logic [WORD_W-1:0] tx_hold;
      logic [WORD_W-1:0] cmd_word;
      logic cmd_valid;
      logic data_valid;
   } isr_sys_t;

   typedef struct packed {
      logic [WORD_W-2:0] shift;
      logic [BIT_CNT_W-1:0] cnt;
   } isr_rx_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic tgl;
   } isr_rxw_t;

   typedef struct packed {
      logic [BIT_CNT_W-1:0] idx;
      logic miso;
   } isr_tx_t;

   localparam isr_sys_t SYS_RST = '{
      phase: ST_BOOT,
      busy_cnt: STARTUP_LOAD,
      smp_cnt: SMP_LOAD,
      hwrst_s1_n: 1'b1,
      hwrst_s2_n: 1'b1,
      default: '0
   };

   isr_sys_t sys_ff;
   isr_sys_t nxt_sys_ff;
   isr_rx_t rx_ff;
   isr_rx_t nxt_rx_ff;
   isr_rxw_t rxw_ff;
   isr_rxw_t nxt_rxw_ff;
   isr_tx_t tx_ff;
   isr_tx_t nxt_tx_ff;

   logic spi_rst_n;
   logic run;
   logic ext_mode;
   logic sync_rise;
   logic word_evt;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;

   assign run = sys_ff.phase == ST_RUN;
   assign ext_mode = sync_sel && (sample_period_setting == SMPL_SYNC_SETTING);
   assign sync_rise = sys_ff.sync_s2 & ~sys_ff.sync_s3;
   assign word_evt = sys_ff.word_s2 ^ sys_ff.word_s3;

   // Samples are only accepted while output data is valid
   assign fifo_in_valid = smp_valid & run;
   assign smp_ready = fifo_in_ready & run;

   isr_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst_n(resetn),
      .in_valid(fifo_in_valid),
      .in_data(smp_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(word_evt)
   );

   always_comb begin
      logic fire;
      fire = 1'b0;
      nxt_sys_ff = sys_ff;
      nxt_sys_ff.sync_s1 = sync_clock_pin_i;
      nxt_sys_ff.sync_s2 = sys_ff.sync_s1;
      nxt_sys_ff.sync_s3 = sys_ff.sync_s2;
      nxt_sys_ff.hwrst_s1_n = rst_pin_n;
      nxt_sys_ff.hwrst_s2_n = sys_ff.hwrst_s1_n;
      nxt_sys_ff.word_s1 = rxw_ff.tgl;
      nxt_sys_ff.word_s2 = sys_ff.word_s1;
      nxt_sys_ff.word_s3 = sys_ff.word_s2;
      nxt_sys_ff.cmd_valid = 1'b0;

      case (sys_ff.phase)
         ST_BOOT, ST_RECOVER, ST_FLASH, ST_SELFTEST: begin
            if (sys_ff.busy_cnt == '0) begin
               nxt_sys_ff.phase = ST_RUN;
            end else begin
               nxt_sys_ff.busy_cnt = sys_ff.busy_cnt - 1'b1;
            end
         end
         ST_RUN: begin
            if (flash_test_start) begin
               nxt_sys_ff.phase = ST_FLASH;
               nxt_sys_ff.busy_cnt = FLASH_LOAD;
            end else if (self_test_start) begin
               nxt_sys_ff.phase = ST_SELFTEST;
               nxt_sys_ff.busy_cnt = SELF_LOAD;
            end
         end
         default: begin
            nxt_sys_ff.phase = ST_BOOT;
            nxt_sys_ff.busy_cnt = STARTUP_LOAD;
         end
      endcase
      if (!sys_ff.hwrst_s2_n) begin
         nxt_sys_ff.phase = ST_RECOVER;
         nxt_sys_ff.busy_cnt = RECOVER_LOAD;
      end
      nxt_sys_ff.data_valid = nxt_sys_ff.phase == ST_RUN;

      if (!run) begin
         nxt_sys_ff.smp_cnt = SMP_LOAD;
         nxt_sys_ff.dly_run = 1'b0;
      end else if (ext_mode) begin
         nxt_sys_ff.smp_cnt = SMP_LOAD;
         if (sync_rise) begin
            nxt_sys_ff.dly_run = 1'b1;
            nxt_sys_ff.dly_cnt = DLY_LOAD;
         end else if (sys_ff.dly_run) begin
            if (sys_ff.dly_cnt == '0) begin
               fire = 1'b1;
               nxt_sys_ff.dly_run = 1'b0;
            end else begin
               nxt_sys_ff.dly_cnt = sys_ff.dly_cnt - 1'b1;
            end
         end
      end else begin
         nxt_sys_ff.dly_run = 1'b0;
         if (sys_ff.smp_cnt == '0) begin
            fire = 1'b1;
            nxt_sys_ff.smp_cnt = SMP_LOAD;
         end else begin
            nxt_sys_ff.smp_cnt = sys_ff.smp_cnt - 1'b1;
         end
      end

      if (fire) begin
         nxt_sys_ff.dr_cnt = PULSE_LOAD;
         nxt_sys_ff.data_ready = 1'b1;
      end else if (sys_ff.dr_cnt != '0) begin
         nxt_sys_ff.dr_cnt = sys_ff.dr_cnt - 1'b1;
      end else begin
         nxt_sys_ff.data_ready = 1'b0;
      end

      // Word boundary: hand host word in, next output word out
      if (word_evt) begin
         nxt_sys_ff.cmd_word = rxw_ff.word;
         nxt_sys_ff.cmd_valid = 1'b1;
         nxt_sys_ff.tx_hold = fifo_out_valid ? fifo_out_data : WORD_RST;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sys_ff <= SYS_RST;
      end else begin
         sys_ff <= nxt_sys_ff;
      end
   end

   assign cmd_word = sys_ff.cmd_word;
   assign cmd_valid = sys_ff.cmd_valid;
   assign data_valid = sys_ff.data_valid;
   assign data_ready_pin = sys_ff.data_ready;

   // pin shared between general use and sync clock
   assign gpio_four_in = sys_ff.sync_s2;
   assign sync_clock_pin_o = gpio_four_out;
   assign sync_clock_pin_oe = gpio_four_oe & ~sync_sel;

   // frame logic held in reset outside chip select
   assign spi_rst_n = resetn & ~spi_cs_n;

   always_comb begin
      nxt_rx_ff.shift = {rx_ff.shift[WORD_W-3:0], spi_mosi};
      nxt_rx_ff.cnt = rx_ff.cnt + 1'b1;
   end

   always_ff @(posedge spi_sclk or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         rx_ff <= '0;
      end else begin
         rx_ff <= nxt_rx_ff;
      end
   end

   // Completed word survives chip select; its toggle marks the boundary
   always_comb begin
      nxt_rxw_ff = rxw_ff;
      if (rx_ff.cnt == LAST_BIT) begin
         nxt_rxw_ff.word = {rx_ff.shift, spi_mosi};
         nxt_rxw_ff.tgl = ~rxw_ff.tgl;
      end
   end

   always_ff @(posedge spi_sclk or negedge resetn) begin
      if (!resetn) begin
         rxw_ff <= '0;
      end else begin
         rxw_ff <= nxt_rxw_ff;
      end
   end

   // tx_hold is quasi-static: it only moves a few system clocks after a
   // word ends, well inside the host's gap between words
   always_comb begin
      nxt_tx_ff.miso = sys_ff.tx_hold[~tx_ff.idx];
      nxt_tx_ff.idx = tx_ff.idx + 1'b1;
   end

   always_ff @(negedge spi_sclk or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         tx_ff <= '{idx: BIT_CNT_RST, miso: 1'b0};
      end else begin
         tx_ff <= nxt_tx_ff;
      end
   end

   assign spi_miso_o = tx_ff.miso;
   assign spi_miso_oe = ~spi_cs_n;
endmodule
`default_nettype wire
